/* rtl/srp_pkg.sv */
// Package for the serial register port: frame layout, register map, reset values.
// Assumes use by both ends of the serial link, the checker and the bench.
package srp_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS  = 7;
  localparam int DATA_BITS  = 8;
  localparam int HEAD_BITS  = 8;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ  = 1'h1;

  // ****************************************************************
  // Device register map
  // ****************************************************************
  localparam logic [6:0] SOFT_RESET_KEY_ADDR = 7'h5F;
  localparam logic [7:0] SOFT_RESET_KEY_VAL  = 8'hAA;
  localparam logic [7:0] SOFT_RESET_KEY_RST  = 8'h00;
  localparam logic [6:0] IF_SUPPLY_ADDR      = 7'h4A;
  localparam logic [7:0] REG_RST             = 8'h00;

  // ****************************************************************
  // Host register map (Avalon-MM, byte addresses)
  // ****************************************************************
  localparam logic [3:0] HOST_CMD_OFS    = 4'h0;
  localparam logic [3:0] HOST_STATUS_OFS = 4'h4;
  localparam logic [3:0] HOST_RDATA_OFS  = 4'h8;
  localparam logic [3:0] HOST_CTRL_OFS   = 4'hC;
  localparam logic [31:0] HOST_CTRL_RST  = 32'h0000_0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam real MCLK_NS        = 10.0;
  localparam real HW_RESET_MIN_NS = 1000.0;
  localparam int  HW_RESET_CYC   = int'($ceil(HW_RESET_MIN_NS / MCLK_NS));
  localparam int  SCLK_DIV_DEF   = 4;

endpackage

/* rtl/srp_if.sv */
// Interface joining host and device of the serial register port.
// Assumes the bench resolves nothing: all pins are one-way.
`timescale 1ns/1ps
interface srp_if;
  logic sclk;
  logic chip_select_n;
  logic ser_data_in;
  logic ser_data_out;
  logic hw_reset_n;

  modport device
  (
    input  sclk,
    input  chip_select_n,
    input  ser_data_in,
    input  hw_reset_n,
    output ser_data_out
  );

  modport host
  (
    output sclk,
    output chip_select_n,
    output ser_data_in,
    output hw_reset_n,
    input  ser_data_out
  );
endinterface

/* rtl/srp_device.sv */
// Device end of the serial register port: 128 byte registers, soft reset key.
// Assumes the host drives sclk, chip_select_n, ser_data_in and hw_reset_n.
`timescale 1ns/1ps
module srp_device
  import srp_pkg::*;
(
  // Link
  srp_if.device          lnk,
  // User side
  output logic [7:0]     if_supply_sel,
  output logic           soft_reset_seen
);

  // ****************************************************************
  // Reset: pin clears at once, soft key on its commit edge
  // ****************************************************************
  logic       soft_rst_req_r;
  logic       dev_rst_n;

  // Soft reset kept synchronous; a self-gated async reset would glitch
  assign dev_rst_n = lnk.hw_reset_n;

  // ****************************************************************
  // Frame shifter, clocked by the link clock
  // ****************************************************************
  logic [4:0]              cnt_r;
  logic [FRAME_BITS-2:0]   shift_r;
  logic [DATA_BITS-1:0]    regs_r [0:127];
  logic [DATA_BITS-1:0]    rd_byte_r;
  logic                    out_r;
  logic                    is_read;
  logic [ADDR_BITS-1:0]    wr_addr;
  logic [DATA_BITS-1:0]    wr_data;
  logic                    rd_mode_r;
  logic                    wr_hit;
  logic                    key_hit;

  assign is_read = shift_r[HEAD_BITS-2 +: 1] == DIR_READ;
  assign wr_addr = shift_r[FRAME_BITS-3 -: ADDR_BITS];
  assign wr_data = {shift_r[DATA_BITS-2:0], lnk.ser_data_in};
  assign wr_hit  = !lnk.chip_select_n && cnt_r == 5'(FRAME_BITS-1)
                   && shift_r[FRAME_BITS-2] == DIR_WRITE;
  assign key_hit = wr_hit && wr_addr == SOFT_RESET_KEY_ADDR
                   && wr_data == SOFT_RESET_KEY_VAL;

  // Bit count; select high holds it at zero
  always_ff @(posedge lnk.sclk or posedge lnk.chip_select_n)
  begin
    if (lnk.chip_select_n)
      cnt_r <= 5'h00;
    else if (cnt_r != 5'(FRAME_BITS))
      cnt_r <= cnt_r + 5'h01;
  end

  always_ff @(posedge lnk.sclk or negedge dev_rst_n)
  begin
    if (!dev_rst_n)
      shift_r <= '0;
    else if (key_hit)
      shift_r <= '0;
    else if (!lnk.chip_select_n)
      shift_r <= {shift_r[FRAME_BITS-3:0], lnk.ser_data_in};
  end

  // Write commit on the 16th rise only; key clears every register
  always_ff @(posedge lnk.sclk or negedge dev_rst_n)
  begin
    if (!dev_rst_n)
    begin
      for (int i = 0; i < 128; i++)
        regs_r[i] <= REG_RST;
    end
    else if (key_hit)
    begin
      for (int i = 0; i < 128; i++)
        regs_r[i] <= REG_RST;
    end
    else if (wr_hit)
      regs_r[wr_addr] <= wr_data;
  end

  // Soft reset flag, dropped on the next link edge
  always_ff @(posedge lnk.sclk or negedge dev_rst_n)
  begin
    if (!dev_rst_n)
      soft_rst_req_r <= 1'b0;
    else
      soft_rst_req_r <= key_hit;
  end

  // Direction latched with the header
  always_ff @(posedge lnk.sclk or negedge dev_rst_n)
  begin
    if (!dev_rst_n)
      rd_mode_r <= 1'b0;
    else if (!lnk.chip_select_n && cnt_r == 5'(HEAD_BITS-1))
      rd_mode_r <= is_read;
  end

  // Header latched on the 8th rise selects the byte to send
  always_ff @(posedge lnk.sclk or negedge dev_rst_n)
  begin
    if (!dev_rst_n)
      rd_byte_r <= 8'h00;
    else if (!lnk.chip_select_n && cnt_r == 5'(HEAD_BITS-1))
      rd_byte_r <= regs_r[{shift_r[ADDR_BITS-2:0], lnk.ser_data_in}];
    else if (!lnk.chip_select_n)
      rd_byte_r <= {rd_byte_r[DATA_BITS-2:0], 1'b0};
  end

  // Read data driven on falling edges of the 8th to 15th clocks
  always_ff @(negedge lnk.sclk or posedge lnk.chip_select_n)
  begin
    if (lnk.chip_select_n)
      out_r <= 1'b0;
    else if (cnt_r >= 5'(HEAD_BITS) && cnt_r < 5'(FRAME_BITS)
             && rd_mode_r)
      out_r <= rd_byte_r[DATA_BITS-1];
    else
      out_r <= 1'b0;
  end

  assign lnk.ser_data_out = out_r & lnk.hw_reset_n;

  // ****************************************************************
  // User outputs
  // ****************************************************************
  assign if_supply_sel   = regs_r[IF_SUPPLY_ADDR];
  assign soft_reset_seen = soft_rst_req_r;

endmodule

/* rtl/srp_host.sv */
// Host end: Avalon-MM registers command serial frames to the device.
// Assumes one mclk domain; sclk made by division, so no second domain here.
`timescale 1ns/1ps
module srp_host
  import srp_pkg::*;
#(
  parameter int SCLK_DIV = SCLK_DIV_DEF
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Link
  srp_if.host              lnk
);

  typedef enum logic [2:0] {ST_IDLE, ST_RST, ST_SEL, ST_LOW, ST_HIGH, ST_DESEL} srp_state_e;

  srp_state_e  state_r;
  logic [15:0] frame_r;
  logic [4:0]  bit_r;
  logic [15:0] div_r;
  logic [7:0]  rdata_r;
  logic [31:0] ctrl_r;
  logic        busy;
  logic        go;
  logic        tick;
  logic [2:0]  din_sync_r;
  logic        din_r;
  logic        rd_ack_r;

  // ****************************************************************
  // Register bus: writes at once, reads after one wait state
  // ****************************************************************
  assign busy = state_r != ST_IDLE;
  assign go   = avs_write && avs_address == HOST_CMD_OFS && !busy;
  assign avs_waitrequest = avs_read && !rd_ack_r;

  // Read data registered, so the answer comes one cycle late
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rd_ack_r <= 1'b0;
    else
      rd_ack_r <= avs_read && !rd_ack_r;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !rd_ack_r)
    begin
      case (avs_address)
        HOST_STATUS_OFS: avs_readdata <= {31'h0, busy};
        HOST_RDATA_OFS:  avs_readdata <= {24'h0, rdata_r};
        HOST_CTRL_OFS:   avs_readdata <= ctrl_r;
        default:         avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= HOST_CTRL_RST;
    else if (avs_write && avs_address == HOST_CTRL_OFS)
      ctrl_r <= avs_writedata;
  end

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  assign tick = div_r == 16'(SCLK_DIV - 1);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= 16'h0000;
    else if (state_r == ST_IDLE || tick)
      div_r <= 16'h0000;
    else
      div_r <= div_r + 16'h0001;
  end

  // Link read data: three flops, taken once the last two agree
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      din_sync_r <= 3'h0;
      din_r      <= 1'b0;
    end
    else
    begin
      din_sync_r <= {din_sync_r[1:0], lnk.ser_data_out};
      if (din_sync_r[2] == din_sync_r[1])
        din_r <= din_sync_r[2];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_RST;
      frame_r <= 16'h0000;
      bit_r   <= 5'h00;
      rdata_r <= 8'h00;
    end
    else
    begin
      case (state_r)
        ST_RST:
          if (bit_r == 5'h1F)
            state_r <= ST_IDLE;
          else if (tick)
            bit_r <= bit_r + 5'h01;
        ST_IDLE:
          if (go)
          begin
            frame_r <= avs_writedata[15:0];
            bit_r   <= 5'h00;
            state_r <= ST_SEL;
          end
        ST_SEL:
          if (tick)
            state_r <= ST_LOW;
        ST_LOW:
          if (tick)
            state_r <= ST_HIGH;
        ST_HIGH:
          if (tick)
          begin
            frame_r <= {frame_r[14:0], 1'b0};
            if (bit_r >= 5'(HEAD_BITS))
              rdata_r <= {rdata_r[6:0], din_r};
            bit_r <= bit_r + 5'h01;
            state_r <= (bit_r == 5'(FRAME_BITS-1)) ? ST_DESEL : ST_LOW;
          end
        ST_DESEL:
          if (tick)
            state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Link pins, all from flip-flops
  // ****************************************************************
  logic rst_pin_r;
  logic cs_r;
  logic sclk_r;
  logic sdi_r;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_pin_r <= 1'b0;
      cs_r      <= 1'b1;
      sclk_r    <= 1'b0;
      sdi_r     <= 1'b0;
    end
    else
    begin
      rst_pin_r <= !(state_r == ST_RST && bit_r < 5'h1E) && !ctrl_r[0];
      cs_r      <= !(state_r inside {ST_SEL, ST_LOW, ST_HIGH});
      sclk_r    <= state_r == ST_HIGH;
      sdi_r     <= state_r inside {ST_SEL, ST_LOW, ST_HIGH} ? frame_r[15] : 1'b0;
    end
  end

  assign lnk.hw_reset_n    = rst_pin_r;
  assign lnk.chip_select_n = cs_r;
  assign lnk.sclk          = sclk_r;
  assign lnk.ser_data_in   = sdi_r;

endmodule

/* verif/srp_link_chk.sv */
// Checker for the serial link between host and device ends.
// Assumes the bench places it beside the link interface.
`timescale 1ns/1ps
module srp_link_chk
  import srp_pkg::*;
(
  // Link
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic ser_data_in,
  input wire logic ser_data_out,
  input wire logic hw_reset_n
);
  // ********
  // Frame tracking and register shadow
  // ********
  logic [4:0]  cnt_r;
  logic [14:0] sh_r;
  logic [7:0]  hdr_r;
  logic [7:0]  mem_r [128];
  logic [15:0] frm;
  logic [7:0]  rd_byte;
  assign frm     = {sh_r, ser_data_in};
  assign rd_byte = mem_r[hdr_r[6:0]];

  always_ff @(posedge sclk or posedge chip_select_n)
    if (chip_select_n)
      cnt_r <= 5'h00;
    else
      cnt_r <= cnt_r + 5'h01;

  always_ff @(posedge sclk)
  begin
    sh_r <= frm[14:0];
    if (cnt_r == 5'h07)
      hdr_r <= frm[7:0];
  end

  always_ff @(posedge sclk or negedge hw_reset_n)
    if (!hw_reset_n)
      mem_r <= '{default: REG_RST};
    else if (cnt_r == 5'h0F && frm[15] == DIR_WRITE)
      if (frm[14:0] == {SOFT_RESET_KEY_ADDR, SOFT_RESET_KEY_VAL})
        mem_r <= '{default: REG_RST};
      else
        mem_r[frm[14:8]] <= frm[7:0];

  // ********
  // Properties
  // ********
  property p_head_low;
    @(posedge sclk) disable iff (!hw_reset_n) cnt_r < 5'h08 |-> !ser_data_out;
  endproperty
  a_head_low: assert property (p_head_low) else $error("data out in header");

  property p_wr_quiet;
    @(posedge sclk) disable iff (!hw_reset_n)
      cnt_r > 5'h07 && hdr_r[7] == DIR_WRITE |-> !ser_data_out;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("data out in write");

  property p_rd_zero;
    @(posedge sclk) disable iff (!hw_reset_n)
      cnt_r > 5'h07 && hdr_r[7] == DIR_READ && rd_byte == 8'h00 |-> !ser_data_out;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("cleared reg not 0");

  property p_rd_bits;
    @(posedge sclk) disable iff (!hw_reset_n) cnt_r > 5'h07 && hdr_r[7] == DIR_READ
      |-> ser_data_out == rd_byte[5'h0F - cnt_r];
  endproperty
  a_rd_bits: assert property (p_rd_bits) else $error("read bit wrong");

  property p_frame_max;
    @(posedge sclk) disable iff (!hw_reset_n) cnt_r < 5'h10;
  endproperty
  a_frame_max: assert property (p_frame_max) else $error("over 16 clocks");

  property p_full_frame;
    @(posedge chip_select_n) disable iff (!hw_reset_n) cnt_r != 5'h00 |-> cnt_r == 5'h10;
  endproperty
  a_full_frame: assert property (p_full_frame) else $error("short frame");

  property p_start_idle;
    @(negedge chip_select_n) disable iff (!hw_reset_n) !sclk && !ser_data_out;
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("bad idle");

  property p_rst_static;
    @(posedge hw_reset_n) chip_select_n && !sclk && !ser_data_in;
  endproperty
  a_rst_static: assert property (p_rst_static) else $error("lines moved");
endmodule

/* verif/testbench.sv */
// Bench: host and device joined by the link, driven over Avalon-MM.
// Assumes the host answers with waitrequest and a STATUS busy bit.
`timescale 1ns/1ps
module testbench
  import srp_pkg::*;
;
  // ********
  // Design, link and checker
  // ********
  logic        mclk;
  logic        rst_n;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  if_supply_sel;
  logic        soft_reset_seen;
  logic [31:0] q;
  logic [6:0]  a;
  logic [7:0]  d;
  int          err_total;
  int          checks;
  int          mem [128];

  srp_if lnk ();
  srp_host srp_host_i (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lnk(lnk));
  srp_device srp_device_i (.lnk(lnk), .if_supply_sel(if_supply_sel),
    .soft_reset_seen(soft_reset_seen));
  srp_link_chk srp_link_chk_i (.sclk(lnk.sclk), .chip_select_n(lnk.chip_select_n),
    .ser_data_in(lnk.ser_data_in), .ser_data_out(lnk.ser_data_out),
    .hw_reset_n(lnk.hw_reset_n));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ********
  // Tasks
  // ********
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task av(input logic wr, input logic [3:0] ad, input logic [31:0] dt, output logic [31:0] r);
    @(posedge mclk);
    avs_address <= ad;
    avs_writedata <= dt;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task idle;
    logic [31:0] r;
    int          n;
    n = 0;
    do
    begin
      av(1'b0, HOST_STATUS_OFS, 32'h0, r);
      n++;
    end
    while (r[0] !== 1'b0 && n < 600);
    chk(r & 32'h1, 32'h0);
  endtask

  task xfer(input logic dir, input logic [6:0] ad, input logic [7:0] dt);
    logic [31:0] r;
    av(1'b1, HOST_CMD_OFS, {16'h0000, dir, ad, dt}, r);
    idle();
    if (dir == DIR_READ)
    begin
      av(1'b0, HOST_RDATA_OFS, 32'h0, r);
      chk(r & 32'hFF, 32'(mem[ad]));
    end
    else if ({ad, dt} == {SOFT_RESET_KEY_ADDR, SOFT_RESET_KEY_VAL})
      mem = '{default: 0};
    else
      mem[ad] = dt;
  endtask

  task tally_and_finish;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    err_total++;
    tally_and_finish();
  end

  // ********
  // Tests
  // ********
  initial
  begin
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_total = 0;
    checks = 0;
    mem = '{default: 0};
    void'($urandom(32'hFD000FD1));
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    idle();
    av(1'b0, HOST_CTRL_OFS, 32'h0, q);
    chk(q, HOST_CTRL_RST);
    for (int i = 0; i < 4; i++)
      xfer(DIR_READ, 7'($urandom), 8'h00);
    $display("reset values done");
    for (int i = 0; i < 12; i++)
    begin
      a = (i == 0) ? 7'h7F : 7'($urandom % 95);
      d = (i < 2) ? {8{i[0]}} : 8'($urandom);
      xfer(DIR_WRITE, a, d);
      xfer(DIR_READ, a, 8'h00);
    end
    $display("write read done");
    xfer(DIR_WRITE, IF_SUPPLY_ADDR, 8'h01);
    chk({24'h0, if_supply_sel}, 32'h1);
    xfer(DIR_WRITE, SOFT_RESET_KEY_ADDR, SOFT_RESET_KEY_VAL);
    chk({31'h0, soft_reset_seen}, 32'h1);
    xfer(DIR_READ, SOFT_RESET_KEY_ADDR, 8'h00);
    chk({24'h0, if_supply_sel}, 32'h0);
    chk({31'h0, soft_reset_seen}, 32'h0);
    $display("soft reset done");
    xfer(DIR_WRITE, IF_SUPPLY_ADDR, 8'h01);
    xfer(DIR_READ, IF_SUPPLY_ADDR, 8'h00);
    av(1'b1, HOST_CTRL_OFS, 32'h1, q);
    repeat (HW_RESET_CYC) @(posedge mclk);
    av(1'b1, HOST_CTRL_OFS, 32'h0, q);
    idle();
    mem = '{default: 0};
    chk({24'h0, if_supply_sel}, 32'h0);
    xfer(DIR_READ, IF_SUPPLY_ADDR, 8'h00);
    $display("hardware reset done");
    xfer(DIR_WRITE, 7'h10, 8'h5A);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    idle();
    mem = '{default: 0};
    xfer(DIR_READ, 7'h10, 8'h00);
    av(1'b1, 4'h2, 32'h0000FFFF, q);
    av(1'b0, HOST_STATUS_OFS, 32'h0, q);
    chk(q & 32'h1, 32'h0);
    $display("second reset and unmapped done");
    tally_and_finish();
  end
endmodule
